// ### rtl/ida_pkg.sv
// Package of the indirect data addressing unit: register offsets, widths and carriers.
// Assumes a 12-bit data memory space and an Avalon-MM register port of 32-bit words.
package ida_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // Register offsets in the special-function space.
    localparam logic [11:0] OFS_P2_LOW = 12'h0fd9;
    localparam logic [11:0] OFS_P2_HIGH = 12'h0fda;
    localparam logic [11:0] OFS_P2_PLUSW = 12'h0fdb;
    localparam logic [11:0] OFS_P2_PREINC = 12'h0fdc;
    localparam logic [11:0] OFS_P2_POSTDEC = 12'h0fdd;
    localparam logic [11:0] OFS_P2_POSTINC = 12'h0fde;
    localparam logic [11:0] OFS_P2_PLAIN = 12'h0fdf;
    localparam logic [11:0] OFS_P1_LOW = 12'h0fe1;
    localparam logic [11:0] OFS_P1_HIGH = 12'h0fe2;
    localparam logic [11:0] OFS_P1_PLUSW = 12'h0fe3;
    localparam logic [11:0] OFS_P1_PREINC = 12'h0fe4;
    localparam logic [11:0] OFS_P1_POSTDEC = 12'h0fe5;
    localparam logic [11:0] OFS_P1_POSTINC = 12'h0fe6;
    localparam logic [11:0] OFS_P1_PLAIN = 12'h0fe7;
    localparam logic [11:0] OFS_P0_LOW = 12'h0fe9;
    localparam logic [11:0] OFS_P0_HIGH = 12'h0fea;
    localparam logic [11:0] OFS_P0_PLUSW = 12'h0feb;
    localparam logic [11:0] OFS_P0_PREINC = 12'h0fec;
    localparam logic [11:0] OFS_P0_POSTDEC = 12'h0fed;
    localparam logic [11:0] OFS_P0_POSTINC = 12'h0fee;
    localparam logic [11:0] OFS_P0_PLAIN = 12'h0fef;
    localparam logic [11:0] OFS_WORKING = 12'h0ff0;

    // Reset values.
    localparam logic [11:0] PTR_RESET = 12'h0000;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic [7:0] HIGH_UNUSED_MASK = 8'h0f;

    // Kinds of operand access.
    typedef enum logic [2:0] {
        IDA_OP_LOW,
        IDA_OP_HIGH,
        IDA_OP_PLAIN,
        IDA_OP_POSTINC,
        IDA_OP_POSTDEC,
        IDA_OP_PREINC,
        IDA_OP_PLUSW,
        IDA_OP_NONE
    } ida_op_type;

    // Decoded register address.
    typedef struct packed {
        logic hit;
        logic [1:0] ptr;
        ida_op_type op;
    } ida_decode_type;

    // One data memory request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } ida_mem_req_type;

endpackage : ida_pkg

// ### rtl/ida_pointer.sv
// One pointer pair: 12-bit pointer with load of each byte and step by one.
// Assumes the parent decides at most one update per cycle.
`timescale 1ns/1ps

module ida_pointer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load_low,
    input wire logic load_high,
    input wire logic step_up,
    input wire logic step_down,
    input wire logic [7:0] wdata,
    output logic [11:0] value_q
);

    // Byte loads, then post or pre steps, wrapping in the flat 12-bit range.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= ida_pkg::PTR_RESET;
        end else if (load_low) begin
            value_q <= {value_q[11:8], wdata};
        end else if (load_high) begin
            value_q <= {wdata[3:0], value_q[7:0]};
        end else if (step_up) begin
            value_q <= value_q + 12'h001;
        end else if (step_down) begin
            value_q <= value_q - 12'h001;
        end
    end

endmodule : ida_pointer

// ### rtl/ida_unit.sv
// Indirect data addressing unit with three pointer pairs and virtual operands.
// Assumes a data memory that answers a read one cycle after the request.
`timescale 1ns/1ps

// What this block does
// - Three independent pointers, each built from a high and a low byte register.
// - Only the low four bits of each high byte exist, giving a 12-bit pointer.
// - The pointer addresses the whole data memory as one flat range.
// - The operand addresses hold no storage of their own.
// - Accessing an operand reads or writes memory at the matching pointer.
// - Instructions naming an operand use the pointer as their target address.
// - The plain operand leaves its pointer unchanged.
// - Bank select and access-bank bit have no effect on the target address.
// - The plus-offset operand targets pointer plus the working register.
module ida_unit (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] bank_select_value,
    input wire logic access_bank_bit,
    output ida_pkg::ida_mem_req_type mem_req_q,
    input wire logic [7:0] mem_rdata
);

    typedef enum logic [1:0] {
        IDA_IDLE,
        IDA_MEM,
        IDA_WAIT,
        IDA_DONE
    } ida_state_type;

    ida_state_type state_q;
    logic [11:0] ptr_val [3];
    logic [7:0] wreg_q;
    logic [31:0] rdata_q;
    logic wait_q;
    logic [2:0] load_low;
    logic [2:0] load_high;
    logic [2:0] step_up;
    logic [2:0] step_down;
    ida_pkg::ida_decode_type dec;
    logic [11:0] reg_addr;
    logic [11:0] target;
    logic [7:0] wbyte;
    logic lane_ok;
    logic start;

    // Register index is the word address; only the low lane carries data.
    assign reg_addr = avs_address[11:0];
    assign lane_ok = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign start = (state_q == IDA_IDLE) && (avs_read || avs_write);

    // Address decode into pointer number and operand kind.
    always_comb begin
        dec = '{hit: 1'b1, ptr: 2'd0, op: ida_pkg::IDA_OP_NONE};
        unique case (reg_addr)
            ida_pkg::OFS_P0_LOW: dec = '{1'b1, 2'd0, ida_pkg::IDA_OP_LOW};
            ida_pkg::OFS_P0_HIGH: dec = '{1'b1, 2'd0, ida_pkg::IDA_OP_HIGH};
            ida_pkg::OFS_P0_PLAIN: dec = '{1'b1, 2'd0, ida_pkg::IDA_OP_PLAIN};
            ida_pkg::OFS_P0_POSTINC: dec = '{1'b1, 2'd0, ida_pkg::IDA_OP_POSTINC};
            ida_pkg::OFS_P0_POSTDEC: dec = '{1'b1, 2'd0, ida_pkg::IDA_OP_POSTDEC};
            ida_pkg::OFS_P0_PREINC: dec = '{1'b1, 2'd0, ida_pkg::IDA_OP_PREINC};
            ida_pkg::OFS_P0_PLUSW: dec = '{1'b1, 2'd0, ida_pkg::IDA_OP_PLUSW};
            ida_pkg::OFS_P1_LOW: dec = '{1'b1, 2'd1, ida_pkg::IDA_OP_LOW};
            ida_pkg::OFS_P1_HIGH: dec = '{1'b1, 2'd1, ida_pkg::IDA_OP_HIGH};
            ida_pkg::OFS_P1_PLAIN: dec = '{1'b1, 2'd1, ida_pkg::IDA_OP_PLAIN};
            ida_pkg::OFS_P1_POSTINC: dec = '{1'b1, 2'd1, ida_pkg::IDA_OP_POSTINC};
            ida_pkg::OFS_P1_POSTDEC: dec = '{1'b1, 2'd1, ida_pkg::IDA_OP_POSTDEC};
            ida_pkg::OFS_P1_PREINC: dec = '{1'b1, 2'd1, ida_pkg::IDA_OP_PREINC};
            ida_pkg::OFS_P1_PLUSW: dec = '{1'b1, 2'd1, ida_pkg::IDA_OP_PLUSW};
            ida_pkg::OFS_P2_LOW: dec = '{1'b1, 2'd2, ida_pkg::IDA_OP_LOW};
            ida_pkg::OFS_P2_HIGH: dec = '{1'b1, 2'd2, ida_pkg::IDA_OP_HIGH};
            ida_pkg::OFS_P2_PLAIN: dec = '{1'b1, 2'd2, ida_pkg::IDA_OP_PLAIN};
            ida_pkg::OFS_P2_POSTINC: dec = '{1'b1, 2'd2, ida_pkg::IDA_OP_POSTINC};
            ida_pkg::OFS_P2_POSTDEC: dec = '{1'b1, 2'd2, ida_pkg::IDA_OP_POSTDEC};
            ida_pkg::OFS_P2_PREINC: dec = '{1'b1, 2'd2, ida_pkg::IDA_OP_PREINC};
            ida_pkg::OFS_P2_PLUSW: dec = '{1'b1, 2'd2, ida_pkg::IDA_OP_PLUSW};
            ida_pkg::OFS_WORKING: dec = '{1'b1, 2'd0, ida_pkg::IDA_OP_NONE};
            default: dec = '{1'b0, 2'd0, ida_pkg::IDA_OP_NONE};
        endcase
        if (avs_address[13:12] != 2'b00) begin
            dec.hit = 1'b0;
        end
    end

    // Target address: pointer alone, pointer plus one, or pointer plus working register.
    // Bank select and the access-bank bit are deliberately left out of this sum.
    always_comb begin
        target = ptr_val[dec.ptr];
        if (dec.op == ida_pkg::IDA_OP_PREINC) begin
            target = ptr_val[dec.ptr] + 12'h001;
        end else if (dec.op == ida_pkg::IDA_OP_PLUSW) begin
            target = ptr_val[dec.ptr] + {4'h0, wreg_q};
        end
    end

    // Pointer update strobes, issued once when an access is accepted.
    always_comb begin
        load_low = 3'b000;
        load_high = 3'b000;
        step_up = 3'b000;
        step_down = 3'b000;
        if (start && dec.hit && lane_ok) begin
            unique case (dec.op)
                ida_pkg::IDA_OP_LOW: load_low[dec.ptr] = avs_write;
                ida_pkg::IDA_OP_HIGH: load_high[dec.ptr] = avs_write;
                ida_pkg::IDA_OP_POSTINC: step_up[dec.ptr] = 1'b1;
                ida_pkg::IDA_OP_PREINC: step_up[dec.ptr] = 1'b1;
                ida_pkg::IDA_OP_POSTDEC: step_down[dec.ptr] = 1'b1;
                ida_pkg::IDA_OP_PLAIN: step_up[dec.ptr] = 1'b0;
                ida_pkg::IDA_OP_PLUSW: step_up[dec.ptr] = 1'b0;
                ida_pkg::IDA_OP_NONE: step_up[dec.ptr] = 1'b0;
            endcase
        end
    end

    // The three pointer pairs.
    for (genvar i = 0; i < 3; i++) begin : g_ptr
        ida_pointer u_ptr (
            .clock(clock),
            .rst_n(rst_n),
            .load_low(load_low[i]),
            .load_high(load_high[i]),
            .step_up(step_up[i]),
            .step_down(step_down[i]),
            .wdata(wbyte),
            .value_q(ptr_val[i])
        );
    end

    // Working register used as the signed-free offset for plus-offset operands.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wreg_q <= ida_pkg::WREG_RESET;
        end else if (start && avs_write && lane_ok && dec.hit
                     && reg_addr == ida_pkg::OFS_WORKING) begin
            wreg_q <= wbyte;
        end
    end

    // Access sequencer: register hits and operand writes finish in two cycles, operand reads go to memory.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IDA_IDLE;
        end else begin
            unique case (state_q)
                IDA_IDLE: begin
                    if (start) begin
                        if (dec.hit && lane_ok && dec.op != ida_pkg::IDA_OP_LOW
                            && dec.op != ida_pkg::IDA_OP_HIGH
                            && dec.op != ida_pkg::IDA_OP_NONE) begin
                            state_q <= avs_read ? IDA_MEM : IDA_DONE;
                        end else begin
                            state_q <= IDA_DONE;
                        end
                    end
                end
                IDA_MEM: state_q <= IDA_WAIT;
                IDA_WAIT: state_q <= IDA_DONE;
                IDA_DONE: state_q <= IDA_IDLE;
            endcase
        end
    end

    // Memory request: one cycle pulse carrying the resolved target.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_q <= '0;
        end else if (start && dec.hit && lane_ok && dec.op != ida_pkg::IDA_OP_LOW
                     && dec.op != ida_pkg::IDA_OP_HIGH && dec.op != ida_pkg::IDA_OP_NONE) begin
            mem_req_q.rd <= avs_read;
            mem_req_q.wr <= avs_write;
            mem_req_q.addr <= target;
            mem_req_q.wdata <= wbyte;
        end else begin
            mem_req_q.rd <= 1'b0;
            mem_req_q.wr <= 1'b0;
        end
    end

    // Read data: pointer bytes, working register, memory byte, zero elsewhere.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (start) begin
            rdata_q <= 32'h0000_0000;
            // A cleared low byte lane turns every register read into zero.
            if (lane_ok && dec.hit && dec.op == ida_pkg::IDA_OP_LOW) begin
                rdata_q[7:0] <= ptr_val[dec.ptr][7:0];
            end else if (lane_ok && dec.hit && dec.op == ida_pkg::IDA_OP_HIGH) begin
                rdata_q[7:0] <= {4'h0, ptr_val[dec.ptr][11:8]};
            end else if (lane_ok && dec.hit && reg_addr == ida_pkg::OFS_WORKING) begin
                rdata_q[7:0] <= wreg_q;
            end
        end else if (state_q == IDA_WAIT) begin
            rdata_q <= {24'h00_0000, mem_rdata};
        end
    end

    // Waitrequest is high except in the answer cycle.
    // An operand read answers only once the memory byte sits in rdata_q.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(state_q == IDA_WAIT || (start && !(avs_read && dec.hit && lane_ok
                        && dec.op != ida_pkg::IDA_OP_LOW && dec.op != ida_pkg::IDA_OP_HIGH
                        && dec.op != ida_pkg::IDA_OP_NONE)));
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

endmodule : ida_unit

// ### verification/ida_checker.sv
// Checker of the indirect addressing unit: bus answer timing and memory request pulses.
// Assumes it is bound to ida_unit and sees only that module's ports.
`timescale 1ns/1ps
module ida_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire ida_pkg::ida_mem_req_type mem_req_q
);
    // All properties share the one clock and its reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_answer;
        !avs_waitrequest;
    endsequence
    property p_rd_pulse; mem_req_q.rd |=> !mem_req_q.rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("memory read pulse too long");
    property p_rd_cause; mem_req_q.rd |-> !mem_req_q.wr && $past(avs_read); endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("memory read without bus read");
    property p_wr_data;
        mem_req_q.wr |-> $past(avs_write) && mem_req_q.wdata == $past(avs_writedata[7:0]);
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("memory write data wrong");
    property p_rd_answer; mem_req_q.rd |-> ##[2:3] s_answer; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("operand read not answered");
    property p_wr_answer; mem_req_q.wr |-> ##[0:1] s_answer; endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("operand write not answered");
    property p_answer_one; s_answer |=> avs_waitrequest; endproperty
    a_answer_one: assert property (p_answer_one)
        else $error("answer longer than one cycle");
    property p_idle_wait; !avs_read && !avs_write |-> avs_waitrequest; endproperty
    a_idle_wait: assert property (p_idle_wait)
        else $error("answer without request");
    property p_data_hold;
        s_answer |=> $stable(avs_readdata) && avs_readdata[31:8] == 24'h0;
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("read data not held");
endmodule : ida_checker
bind ida_unit ida_checker u_chk (.clock(clock), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_req_q(mem_req_q));

// ### verification/ida_mem_model.sv
// Data memory model beside the unit: 4096 bytes with one-cycle read latency.
// Assumes the request struct of the package and the unit's clock.
`timescale 1ns/1ps
module ida_mem_model (
    input wire logic clock,
    input wire ida_pkg::ida_mem_req_type req,
    output logic [7:0] rdata
);
    logic [7:0] mem [4096];
    // Preload a known pattern so every read has a predictable value.
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ i[11:4];
        rdata = 8'h00;
    end
    // One flat address range without banks; read data follows one cycle later.
    always @(posedge clock) begin
        if (req.wr) mem[req.addr] <= req.wdata;
        if (req.rd) rdata <= mem[req.addr];
    end
endmodule : ida_mem_model

// ### verification/indirect_data_addressing_tb.sv
// Self-checking bench of the indirect addressing unit with a data memory model.
// Assumes the Avalon register port and the package offsets of the unit.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module indirect_data_addressing_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] avs_address = 14'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] bank_select_value = 4'h0;
    logic access_bank_bit = 1'b0;
    ida_pkg::ida_mem_req_type mem_req_q;
    logic [7:0] mem_rdata;
    logic [31:0] seed = 32'h0000_2cca;
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] sh [4096];
    logic [11:0] base [3] = '{ida_pkg::OFS_P0_LOW, ida_pkg::OFS_P1_LOW, ida_pkg::OFS_P2_LOW};
    ida_unit DUT (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bank_select_value(bank_select_value),
        .access_bank_bit(access_bank_bit), .mem_req_q(mem_req_q), .mem_rdata(mem_rdata));
    ida_mem_model MEM (.clock(clock), .req(mem_req_q), .rdata(mem_rdata));
    // Free-running clock and a five-cycle reset.
    initial forever #5 clock = ~clock;
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Returns the pointer after the access and the address accessed.
    function automatic logic [23:0] expect_op(int k, logic [11:0] pv, logic [7:0] w);
        case (k)
            2: return {pv, pv + {4'h0, w}};
            3: return {pv + 12'h001, pv + 12'h001};
            4: return {pv - 12'h001, pv};
            5: return {pv + 12'h001, pv};
            default: return {pv, pv};
        endcase
    endfunction : expect_op
    // One Avalon transfer, held until waitrequest is sampled low.
    task automatic bus(input bit wr, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] r);
        int t;
        @(posedge clock);
        avs_address <= {2'b00, a};
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        if (t >= 50) miscompares++;
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // Cuts a hung run short.
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        close_out();
    end
    // Reset values, every operand of every pointer, wrap corners, then refusals.
    initial begin
        logic [31:0] r;
        logic [11:0] pv, a, np;
        logic [7:0] w, d;
        int p, k;
        bit wr;
        for (int i = 0; i < 4096; i++) sh[i] = i[7:0] ^ i[11:4];
        repeat (6) @(posedge clock);
        for (p = 0; p < 3; p++) begin
            bus(0, base[p], 8'h00, r);
            `CHK("low reset", 32'h0, r)
            bus(0, base[p] + 12'h001, 8'h00, r);
            `CHK("high reset", 32'h0, r)
        end
        for (int n = 0; n < 150; n++) begin
            p = n % 3;
            k = 2 + n % 5;
            r = rnd();
            pv = (n < 30) ? {12{n[0]}} : r[11:0];
            w = r[19:12];
            wr = r[20];
            d = r[31:24];
            bus(1, base[p], pv[7:0], r);
            bus(1, base[p] + 12'h001, {d[7:4], pv[11:8]}, r);
            bus(1, ida_pkg::OFS_WORKING, w, r);
            bus(0, ida_pkg::OFS_WORKING, 8'h00, r);
            `CHK("working reg", {24'h0, w}, r)
            bank_select_value <= d[3:0];
            access_bank_bit <= w[0];
            {np, a} = expect_op(k, pv, w);
            bus(wr, base[p] + k[11:0], d, r);
            if (wr) sh[a] = d;
            else `CHK("operand read", {24'h0, sh[a]}, r)
            bus(0, base[p], 8'h00, r);
            `CHK("pointer low", {24'h0, np[7:0]}, r)
            bus(0, base[p] + 12'h001, 8'h00, r);
            `CHK("pointer high", {28'h0, np[11:8]}, r)
            `CHK("memory byte", sh[a], MEM.mem[a])
        end
        bus(0, 12'h0abc, 8'h00, r);
        `CHK("unmapped read", 32'h0, r)
        avs_byteenable <= 4'h0;
        bus(0, base[2], 8'h00, r);
        `CHK("masked read", 32'h0, r)
        close_out();
    end
endmodule : indirect_data_addressing_tb
